/* logic/psm_pkg.sv */
// Purpose: Constants for the power saving mode controller
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes:   Mode select codes follow the two clock mode control bits
// Functional notes
// - Low power entered only on STOP execution
// - Three modes: stop, wake timer, RC watchdog
// - Pending interrupt flag makes STOP a no-op
// - Full stop halts oscillator, timer0, prescaler
// - Ports keep data and direction while asleep
// - Program counter holds address after STOP
// - Select bits 00 choose full stop
// - Full stop ends on reset or external irq
// - Master enable picks vectoring or plain resume
// - External wake from stop counts 00 to FF
// - Wake timer keeps oscillator, prescaler, timer0
// - Wake timer select one chooses wake mode
// - Wake mode ends on reset, overflow, irq
// - Wake mode release skips stabilisation count
// - RC mode runs RC osc, watchdog releases
package psm_pkg;
   localparam int        SEL_W          = 2;
   localparam int        SEL_WAKE_BIT   = 1;
   localparam int        SEL_RC_BIT     = 0;
   localparam int        STAT_W         = 8;
   localparam int        STAT_IE_BIT    = 2;
   localparam int        BIT_W          = 8;
   localparam logic [7:0] BIT_START     = 8'h00;
   localparam logic [7:0] BIT_LAST      = 8'hFF;
   localparam int        STAB_TIME_MS   = 20;
   typedef enum logic [2:0] {
      PSM_RUN    = 3'b000,
      PSM_STOP   = 3'b001,
      PSM_RC_WD  = 3'b011,
      PSM_WAKE   = 3'b010,
      PSM_STAB   = 3'b110,
      PSM_RESUME = 3'b100
   } psm_state_e;
endpackage

/* logic/psm_stab_counter.sv */
// Purpose: Basic interval timer run for oscillator stabilisation
// Assumes: Tick input comes from the selected prescaler tap
// Notes:   Overflow pulse when count passes its last value
`timescale 1ns/1ps
module psm_stab_counter (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // Control
   input  wire logic              start_i,
   input  wire logic              tick_i,
   // Result
   output logic                   ovf_o,
   output logic [psm_pkg::BIT_W-1:0] count_o
);
   logic [psm_pkg::BIT_W-1:0] cnt_reg;
   logic [psm_pkg::BIT_W-1:0] cnt_next;
   logic                      ovf_reg;
   logic                      ovf_next;

   always_comb begin
      cnt_next = cnt_reg;
      ovf_next = 1'b0;
      if (start_i) begin
         cnt_next = psm_pkg::BIT_START;
      end else if (tick_i) begin
         if (cnt_reg == psm_pkg::BIT_LAST) begin
            ovf_next = 1'b1;
         end
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_reg <= psm_pkg::BIT_START;
         ovf_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         ovf_reg <= ovf_next;
      end
   end

   assign ovf_o   = ovf_reg;
   assign count_o = cnt_reg;
endmodule

/* logic/psm_ctrl.sv */
// Purpose: Power saving mode sequencer: entry, hold and release
// Assumes: CPU pulses stop_exec_i when STOP completes
// Notes:   Gates are levels; resume pulses tell the CPU how to go on
`timescale 1ns/1ps
module psm_ctrl (
   // Clock and reset
   input  wire logic                       mclk_i,
   input  wire logic                       rst_i,
   // CPU side
   input  wire logic                       stop_exec_i,
   input  wire logic [psm_pkg::SEL_W-1:0]  mode_sel_i,
   input  wire logic                       irq_pending_i,
   input  wire logic [psm_pkg::STAT_W-1:0] program_status_word_i,
   // Release sources
   input  wire logic                       ext_irq_pin_a_i,
   input  wire logic                       ext_irq_pin_b_i,
   input  wire logic                       timer0_ovf_i,
   input  wire logic                       rc_wdt_event_i,
   input  wire logic                       watchdog_reset_select_i,
   input  wire logic                       bit_tick_i,
   // Clock gating
   output logic                            osc_en_o,
   output logic                            cpu_run_o,
   output logic                            timer0_en_o,
   output logic                            presc_en_o,
   output logic                            presc_2048_only_o,
   output logic                            rc_osc_en_o,
   output logic                            port_hold_o,
   output logic                            pc_hold_o,
   // Resume
   output logic                            vector_irq_o,
   output logic                            resume_next_o,
   output logic                            wdt_reset_o,
   output logic                            sleeping_o
);
   psm_pkg::psm_state_e st_reg;
   psm_pkg::psm_state_e st_next;
   logic                vec_reg, vec_next;
   logic                res_reg, res_next;
   logic                wrst_reg, wrst_next;
   logic                iflag_reg, iflag_next;
   logic                stab_start;
   logic                stab_ovf;
   logic                ext_irq;

   assign ext_irq = ext_irq_pin_a_i | ext_irq_pin_b_i;

   psm_stab_counter u_stab (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .start_i (stab_start),
      .tick_i  (bit_tick_i),
      .ovf_o   (stab_ovf),
      .count_o ()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencing
   always_comb begin
      st_next    = st_reg;
      vec_next   = 1'b0;
      res_next   = 1'b0;
      wrst_next  = 1'b0;
      iflag_next = iflag_reg;
      stab_start = 1'b0;
      case (st_reg)
         psm_pkg::PSM_RUN: begin
            if (stop_exec_i && !irq_pending_i) begin
               iflag_next = program_status_word_i[psm_pkg::STAT_IE_BIT];
               if (mode_sel_i[psm_pkg::SEL_WAKE_BIT]) begin
                  st_next = psm_pkg::PSM_WAKE;
               end else if (mode_sel_i[psm_pkg::SEL_RC_BIT]) begin
                  st_next = psm_pkg::PSM_RC_WD;
               end else begin
                  st_next = psm_pkg::PSM_STOP;
               end
            end
         end
         psm_pkg::PSM_STOP: begin
            if (ext_irq) begin
               st_next    = psm_pkg::PSM_STAB;
               stab_start = 1'b1;
            end
         end
         psm_pkg::PSM_RC_WD: begin
            if (rc_wdt_event_i && watchdog_reset_select_i) begin
               st_next   = psm_pkg::PSM_RUN;
               wrst_next = 1'b1;
            end else if (ext_irq || rc_wdt_event_i) begin
               st_next    = psm_pkg::PSM_STAB;
               stab_start = 1'b1;
            end
         end
         psm_pkg::PSM_WAKE: begin
            if (ext_irq || timer0_ovf_i) begin
               st_next = psm_pkg::PSM_RESUME;
            end
         end
         psm_pkg::PSM_STAB: begin
            if (stab_ovf) begin
               st_next = psm_pkg::PSM_RESUME;
            end
         end
         psm_pkg::PSM_RESUME: begin
            st_next  = psm_pkg::PSM_RUN;
            vec_next = iflag_reg;
            res_next = !iflag_reg;
         end
         default: begin
            st_next = psm_pkg::PSM_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_reg    <= psm_pkg::PSM_RUN;
         vec_reg   <= 1'b0;
         res_reg   <= 1'b0;
         wrst_reg  <= 1'b0;
         iflag_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         vec_reg   <= vec_next;
         res_reg   <= res_next;
         wrst_reg  <= wrst_next;
         iflag_reg <= iflag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered clock gates
   logic osc_reg, osc_next;
   logic cpu_reg, cpu_next;
   logic t0_reg, t0_next;
   logic pre_reg, pre_next;
   logic p2k_reg, p2k_next;
   logic rc_reg, rc_next;
   logic slp_reg, slp_next;

   always_comb begin
      osc_next = 1'b1;
      cpu_next = 1'b1;
      t0_next  = 1'b1;
      pre_next = 1'b1;
      p2k_next = 1'b0;
      rc_next  = 1'b0;
      slp_next = 1'b1;
      case (st_next)
         psm_pkg::PSM_RUN: begin
            slp_next = 1'b0;
         end
         psm_pkg::PSM_STOP: begin
            osc_next = 1'b0;
            cpu_next = 1'b0;
            t0_next  = 1'b0;
            pre_next = 1'b0;
         end
         psm_pkg::PSM_RC_WD: begin
            osc_next = 1'b0;
            cpu_next = 1'b0;
            t0_next  = 1'b0;
            pre_next = 1'b0;
            rc_next  = 1'b1;
         end
         psm_pkg::PSM_WAKE: begin
            cpu_next = 1'b0;
            p2k_next = 1'b1;
         end
         psm_pkg::PSM_STAB: begin
            cpu_next = 1'b0;
            t0_next  = 1'b0;
         end
         psm_pkg::PSM_RESUME: begin
            cpu_next = 1'b0;
         end
         default: begin
            slp_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         osc_reg <= 1'b1;
         cpu_reg <= 1'b1;
         t0_reg  <= 1'b1;
         pre_reg <= 1'b1;
         p2k_reg <= 1'b0;
         rc_reg  <= 1'b0;
         slp_reg <= 1'b0;
      end else begin
         osc_reg <= osc_next;
         cpu_reg <= cpu_next;
         t0_reg  <= t0_next;
         pre_reg <= pre_next;
         p2k_reg <= p2k_next;
         rc_reg  <= rc_next;
         slp_reg <= slp_next;
      end
   end

   assign osc_en_o          = osc_reg;
   assign cpu_run_o         = cpu_reg;
   assign timer0_en_o       = t0_reg;
   assign presc_en_o        = pre_reg;
   assign presc_2048_only_o = p2k_reg;
   assign rc_osc_en_o       = rc_reg;
   assign port_hold_o       = slp_reg;
   assign pc_hold_o         = slp_reg;
   assign sleeping_o        = slp_reg;
   assign vector_irq_o      = vec_reg;
   assign resume_next_o     = res_reg;
   assign wdt_reset_o       = wrst_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_pending_blocks;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_RUN && stop_exec_i && irq_pending_i) |=> (st_reg == psm_pkg::PSM_RUN);
   endproperty
   a_pending_blocks: assert property (p_pending_blocks) else $error("stop entered with irq pending");

   property p_stop_osc_off;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_RUN && stop_exec_i && !irq_pending_i && mode_sel_i == 2'b00)
         |=> (!osc_en_o && !timer0_en_o && !presc_en_o && !cpu_run_o);
   endproperty
   a_stop_osc_off: assert property (p_stop_osc_off) else $error("full stop left clocks on");

   property p_wake_sel;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_RUN && stop_exec_i && !irq_pending_i && mode_sel_i[1])
         |=> (osc_en_o && timer0_en_o && presc_2048_only_o && !cpu_run_o);
   endproperty
   a_wake_sel: assert property (p_wake_sel) else $error("wake timer mode gating wrong");

   property p_rc_sel;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_RUN && stop_exec_i && !irq_pending_i && mode_sel_i == 2'b01)
         |=> (rc_osc_en_o && !osc_en_o);
   endproperty
   a_rc_sel: assert property (p_rc_sel) else $error("rc watchdog mode gating wrong");

   property p_no_stop_entry;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_RUN && !stop_exec_i) |=> !sleeping_o;
   endproperty
   a_no_stop_entry: assert property (p_no_stop_entry) else $error("sleep without stop");

   property p_wake_fast;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_WAKE && timer0_ovf_i) |=> ##1 (cpu_run_o && (vector_irq_o ^ resume_next_o));
   endproperty
   a_wake_fast: assert property (p_wake_fast) else $error("wake release not immediate");

   property p_stop_holds;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_STOP && !ext_irq) |=> (st_reg == psm_pkg::PSM_STOP);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("stop left without release");

   property p_stab_wait;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_STAB && !stab_ovf) |=> !cpu_run_o;
   endproperty
   a_stab_wait: assert property (p_stab_wait) else $error("ran before stabilisation");

   property p_iflag_vector;
      @(posedge mclk_i) disable iff (rst_i)
      (st_reg == psm_pkg::PSM_RESUME) |=> (vector_irq_o == $past(iflag_reg) && resume_next_o == !$past(iflag_reg));
   endproperty
   a_iflag_vector: assert property (p_iflag_vector) else $error("resume path wrong");

   property p_hold_ports;
      @(posedge mclk_i) disable iff (rst_i)
      (port_hold_o == (st_reg != psm_pkg::PSM_RUN)) && (pc_hold_o == (st_reg != psm_pkg::PSM_RUN));
   endproperty
   a_hold_ports: assert property (p_hold_ports) else $error("ports or pc not held");
endmodule

/* bench/psm_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the power saving mode sequencer
// Assumes: Gate outputs packed as osc,cpu,timer0,presc,2048,rc,port,pc
// Notes:   Resume pulses are counted on every rising edge and compared in each wake, sleep and watchdog scenario
`timescale 1ns/1ps
module psm_ctrl_tb_top;
   logic       mclk_i, rst_i, stop_exec_i, irq_pending_i;
   logic       ext_a, ext_b, t0_ovf, rc_ev, wdt_rst_sel, tick;
   logic [1:0] mode_sel;
   logic [7:0] status_word;
   logic       osc_en_o, cpu_run_o, timer0_en_o, presc_en_o, presc_2048_only_o;
   logic       rc_osc_en_o, port_hold_o, pc_hold_o, vector_irq_o, resume_next_o;
   logic       wdt_reset_o, sleeping_o;
   logic [7:0] gates;
   int         n_errors, comparisons, cyc, n_vec, n_res, n_wdt, v0, r0, w0;
   assign gates = {osc_en_o, cpu_run_o, timer0_en_o, presc_en_o, presc_2048_only_o,
                   rc_osc_en_o, port_hold_o, pc_hold_o};
   psm_ctrl dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .stop_exec_i(stop_exec_i),
      .mode_sel_i(mode_sel), .irq_pending_i(irq_pending_i), .program_status_word_i(status_word),
      .ext_irq_pin_a_i(ext_a), .ext_irq_pin_b_i(ext_b), .timer0_ovf_i(t0_ovf),
      .rc_wdt_event_i(rc_ev), .watchdog_reset_select_i(wdt_rst_sel), .bit_tick_i(tick),
      .osc_en_o(osc_en_o), .cpu_run_o(cpu_run_o), .timer0_en_o(timer0_en_o),
      .presc_en_o(presc_en_o), .presc_2048_only_o(presc_2048_only_o),
      .rc_osc_en_o(rc_osc_en_o), .port_hold_o(port_hold_o), .pc_hold_o(pc_hold_o),
      .vector_irq_o(vector_irq_o), .resume_next_o(resume_next_o),
      .wdt_reset_o(wdt_reset_o), .sleeping_o(sleeping_o));
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (vector_irq_o === 1'b1) n_vec++;
      if (resume_next_o === 1'b1) n_res++;
      if (wdt_reset_o === 1'b1) n_wdt++;
      if (cyc == 20000) begin
         n_errors++;
         $display("MISMATCH run time expected below 20000 cycles seen %0d", cyc);
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_gates(input logic [7:0] exp, input int lim, input string what);
      for (int i = 0; i < lim; i++) begin
         @(posedge mclk_i);
         #1;
         if (gates === exp) break;
      end
      chk(what, exp, gates);
   endtask
   task automatic snap();
      v0 = n_vec;
      r0 = n_res;
      w0 = n_wdt;
   endtask
   task automatic check_pulses(input int v, input int r, input int w);
      repeat (2) @(posedge mclk_i);
      #1;
      chk("vector pulses", 8'(v), 8'(n_vec - v0));
      chk("resume pulses", 8'(r), 8'(n_res - r0));
      chk("reset pulses", 8'(w), 8'(n_wdt - w0));
      chk("sleeping after release", 8'h00, {7'h00, sleeping_o});
   endtask
   // Select and flag are flipped after entry: the taken values must hold
   task automatic stop_cmd(input logic [1:0] sel, input logic iflag);
      @(posedge mclk_i);
      mode_sel    <= sel;
      status_word <= iflag ? 8'h04 : 8'h00;
      stop_exec_i <= 1'b1;
      @(posedge mclk_i);
      stop_exec_i <= 1'b0;
      @(posedge mclk_i);
      mode_sel    <= ~sel;
      status_word <= iflag ? 8'h00 : 8'h04;
   endtask
   task automatic pulse_in(input int which);
      @(posedge mclk_i);
      case (which)
         0: ext_a <= 1'b1;
         1: ext_b <= 1'b1;
         2: t0_ovf <= 1'b1;
         3: rc_ev <= 1'b1;
         default: tick <= 1'b1;
      endcase
      @(posedge mclk_i);
      {ext_a, ext_b, t0_ovf, rc_ev, tick} <= 5'h00;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_refused();
      @(posedge mclk_i);
      irq_pending_i <= 1'b1;
      stop_cmd(2'b10, 1'b1);
      repeat (4) @(posedge mclk_i);
      #1;
      chk("gates after refused stop", 8'hF0, gates);
      @(posedge mclk_i);
      irq_pending_i <= 1'b0;
   endtask
   task automatic t_wake(input logic [1:0] sel, input int src, input logic iflag);
      snap();
      stop_cmd(sel, iflag);
      wait_gates(8'hBB, 4, "wake gates");
      pulse_in(3);
      pulse_in(4);
      repeat (3) @(posedge mclk_i);
      #1;
      chk("wake gates held", 8'hBB, gates);
      chk("sleeping in wake", 8'h01, {7'h00, sleeping_o});
      pulse_in(src);
      wait_gates(8'hF0, 4, "wake release");
      check_pulses(iflag, !iflag, 0);
   endtask
   task automatic t_sleep(input logic [1:0] sel, input logic [7:0] g, input int src, input logic iflag);
      stop_cmd(sel, iflag);
      wait_gates(g, 4, "sleep gates");
      pulse_in(2);
      repeat (3) @(posedge mclk_i);
      #1;
      chk("sleep gates held", g, gates);
      chk("sleeping in sleep", 8'h01, {7'h00, sleeping_o});
      snap();
      pulse_in(src);
      wait_gates(8'h93, 4, "stabilise gates");
      repeat (255) pulse_in(4);
      repeat (4) @(posedge mclk_i);
      #1;
      chk("still stabilising at FF", 8'h93, gates);
      pulse_in(4);
      wait_gates(8'hF0, 6, "stabilise release");
      check_pulses(iflag, !iflag, 0);
   endtask
   task automatic t_wdt_reset();
      @(posedge mclk_i);
      wdt_rst_sel <= 1'b1;
      stop_cmd(2'b01, 1'b1);
      wait_gates(8'h07, 4, "rc gates");
      snap();
      pulse_in(3);
      wait_gates(8'hF0, 4, "watchdog release");
      check_pulses(0, 0, 1);
      @(posedge mclk_i);
      wdt_rst_sel <= 1'b0;
   endtask
   task automatic t_mid_reset();
      stop_cmd(2'b00, 1'b0);
      wait_gates(8'h03, 4, "stop gates");
      @(posedge mclk_i);
      rst_i <= 1'b1;
      @(posedge mclk_i);
      #1;
      chk("gates after reset", 8'hF0, gates);
      @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      chk("gates after reset release", 8'hF0, gates);
      chk("sleeping after reset", 8'h00, {7'h00, sleeping_o});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {stop_exec_i, irq_pending_i, ext_a, ext_b, t0_ovf, rc_ev, wdt_rst_sel, tick} = 8'h00;
      {n_errors, comparisons, cyc, n_vec, n_res, n_wdt} = {6{32'sh0}};
      mode_sel = 2'h0;
      status_word = 8'h00;
      rst_i    = 1'b1;
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk("gates after reset", 8'hF0, gates);
      t_refused();
      t_wake(2'b10, 2, 1'b1);
      t_wake(2'b11, 1, 1'b0);
      t_sleep(2'b00, 8'h03, 0, 1'b0);
      t_sleep(2'b00, 8'h03, 1, 1'b1);
      t_sleep(2'b01, 8'h07, 3, 1'b1);
      t_wdt_reset();
      t_mid_reset();
      print_verdict();
   end
endmodule
